// ### dlt_tester.sv
// Dual-window limit tester with an APB register slave.
// Assumes finished readings arrive synchronously to clk_i, one per strobe.
//
// What this block does
// - Two limit sets, each tested per reading.
// - Reset bounds: +1/-1 and +2/-2.
// - Set two may be narrower; no ordering.
// - Inside both sets reports in, no indicator.
// - Failure shows direction and failing set number.
// - Outside both reports set one direction.
// - Overflow flags range, high, hides set status.
// - Overflow never asserts the low indicator.
// - Closed channel shows short inside status.
// - Test processed result, not raw input.
// - Ratio/average: test combined result only.
// - No testing under continuity function.
// - Buffered readings keep status for recall.
// - Remote reading may append its status.
// - Beeper never option stays silent.
// - Outside option beeps on any failure.
// - Inside option: normal tone, lower tone.
// - Inside option silent outside both sets.
// - Reaching a bound counts as failing.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`default_nettype none
module dlt_tester
    import dlt_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     resetn_i,
    // APB slave.
    input  wire logic                     psel_i,
    input  wire logic                     penable_i,
    input  wire logic                     pwrite_i,
    input  wire logic [ADDR_W-1:0]        paddr_i,
    input  wire logic [DATA_W-1:0]        pwdata_i,
    output logic      [DATA_W-1:0]        prdata_o,
    output logic                          pready_o,
    output logic                          pslverr_o,
    // Finished readings from the processing chain.
    input  wire logic                     reading_valid_i,
    input  wire logic signed [DATA_W-1:0] reading_i,
    input  wire logic                     reading_overflow_i,
    input  wire logic                     reading_store_i,
    input  wire logic                     continuity_function_i,
    input  wire logic                     channel_closed_i,
    // Indicators.
    output logic                          status_valid_o,
    output logic                          high_o,
    output logic                          low_o,
    output logic                          in_limits_o,
    output logic                          inside_short_o,
    output logic      [1:0]               fail_set_o,
    output logic                          range_exceeded_status_o,
    output logic                          beep_normal_o,
    output logic                          beep_lower_o
);

    typedef struct packed {
        logic                              enable;
        logic [1:0]                        beep_mode;
        logic                              append;
        logic signed [DATA_W-1:0]          upper_bound_one;
        logic signed [DATA_W-1:0]          lower_bound_one;
        logic signed [DATA_W-1:0]          upper_bound_two;
        logic signed [DATA_W-1:0]          lower_bound_two;
        logic        [DATA_W-1:0]          last_reading;
        logic        [STAT_W-1:0]          status;
        logic                              status_valid;
        logic                              beep_normal;
        logic                              beep_lower;
        logic        [PTR_W-1:0]           wr_ptr;
        logic        [CNT_W-1:0]           count;
        logic        [PTR_W-1:0]           recall_index;
        logic [BUF_DEPTH-1:0][STAT_W-1:0]  status_buf;
        logic        [DATA_W-1:0]          rdata;
    } dlt_state_s;

    dlt_state_s state;
    dlt_state_s next_state;

    // Bound checks: reaching a bound already counts as a failure.
    function automatic logic at_or_above(input logic signed [DATA_W-1:0] r,
                                         input logic signed [DATA_W-1:0] b);
        return r >= b;
    endfunction

    function automatic logic at_or_below(input logic signed [DATA_W-1:0] r,
                                         input logic signed [DATA_W-1:0] b);
        return r <= b;
    endfunction

    // Address decode shared by write and error paths.
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        unique case (a)
            OFF_CTRL, OFF_UPPER_ONE, OFF_LOWER_ONE, OFF_UPPER_TWO,
            OFF_LOWER_TWO, OFF_LAST_READING, OFF_LAST_STATUS,
            OFF_RECALL_INDEX, OFF_RECALL_STATUS, OFF_BUF_COUNT: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Per-set comparison results for the current reading.
    logic set1_hi;
    logic set1_lo;
    logic set2_hi;
    logic set2_lo;
    logic fail1;
    logic fail2;
    logic testing;
    logic [STAT_W-1:0] verdict;
    logic tone_normal;
    logic tone_lower;

    // Both sets are checked independently; neither is assumed nested.
    always_comb begin
        set1_hi = at_or_above(reading_i, state.upper_bound_one);
        set1_lo = at_or_below(reading_i, state.lower_bound_one);
        set2_hi = at_or_above(reading_i, state.upper_bound_two);
        set2_lo = at_or_below(reading_i, state.lower_bound_two);
        fail1 = set1_hi | set1_lo;
        fail2 = set2_hi | set2_lo;
    end

    // The reading port carries the chain's final result, so rel, math,
    // ratio and averaging have already been applied before it lands here.
    assign testing = state.enable & ~continuity_function_i;

    // Verdict word for one reading, set one taking priority.
    always_comb begin
        verdict = '0;
        if (testing) begin
            verdict[ST_TESTED] = 1'b1;
            if (reading_overflow_i) begin
                // An overflow counts as positive whatever the polarity.
                verdict[ST_RANGE] = 1'b1;
                verdict[ST_HIGH]  = 1'b1;
            end else if (fail1) begin
                verdict[ST_HIGH] = set1_hi;
                verdict[ST_LOW]  = set1_lo & ~set1_hi;
                verdict[ST_SET_LSB +: 2] = SET_ONE;
            end else if (fail2) begin
                verdict[ST_HIGH] = set2_hi;
                verdict[ST_LOW]  = set2_lo & ~set2_hi;
                verdict[ST_SET_LSB +: 2] = SET_TWO;
            end else if (channel_closed_i) begin
                verdict[ST_INSIDE_S] = 1'b1;
            end else begin
                verdict[ST_IN] = 1'b1;
            end
        end
    end

    // Beeper tone selection from the option and the verdict.
    always_comb begin
        tone_normal = 1'b0;
        tone_lower  = 1'b0;
        if (testing) begin
            unique case (state.beep_mode)
                DLT_BEEP_OUTSIDE: begin
                    // Overflow is an out-of-limits reading, so it beeps too.
                    tone_normal = reading_overflow_i | fail1 | fail2;
                end
                DLT_BEEP_INSIDE: begin
                    if (!reading_overflow_i && !fail1) begin
                        tone_normal = 1'b1;
                    end else if (!reading_overflow_i && !fail2) begin
                        tone_lower = 1'b1;
                    end
                    // Outside both sets both tones stay low.
                end
                default: begin
                    // Never, and the unused code, keep the beeper quiet.
                    tone_normal = 1'b0;
                end
            endcase
        end
    end

    // APB phases; the slave never waits.
    logic apb_setup;
    logic apb_access;
    logic apb_write;
    assign apb_setup  = psel_i & ~penable_i;
    assign apb_access = psel_i & penable_i;
    assign apb_write  = apb_access & pwrite_i & addr_mapped(paddr_i);

    // Next-state logic for the whole block.
    always_comb begin
        next_state = state;
        next_state.status_valid = 1'b0;
        next_state.beep_normal  = 1'b0;
        next_state.beep_lower   = 1'b0;

        // One verdict per completed reading, held until the next one.
        if (reading_valid_i) begin
            next_state.status       = verdict;
            next_state.last_reading = reading_i;
            next_state.status_valid = 1'b1;
            next_state.beep_normal  = tone_normal;
            next_state.beep_lower   = tone_lower;
            if (reading_store_i) begin
                // The oldest entry is overwritten once the store is full.
                next_state.status_buf[state.wr_ptr] = verdict;
                next_state.wr_ptr = state.wr_ptr + 1'b1;
                if (state.count != CNT_W'(BUF_DEPTH)) begin
                    next_state.count = state.count + 1'b1;
                end
            end
        end

        // Register writes take effect only in the access phase.
        if (apb_write) begin
            unique case (paddr_i)
                OFF_CTRL: begin
                    next_state.enable    = pwdata_i[CTRL_ENABLE_BIT];
                    next_state.beep_mode = pwdata_i[CTRL_BEEP_LSB +: 2];
                    next_state.append    = pwdata_i[CTRL_APPEND_BIT];
                end
                OFF_UPPER_ONE: next_state.upper_bound_one = pwdata_i;
                OFF_LOWER_ONE: next_state.lower_bound_one = pwdata_i;
                OFF_UPPER_TWO: next_state.upper_bound_two = pwdata_i;
                OFF_LOWER_TWO: next_state.lower_bound_two = pwdata_i;
                OFF_RECALL_INDEX: next_state.recall_index = pwdata_i[PTR_W-1:0];
                default: begin
                    // Read-only words ignore writes.
                    next_state.rdata = state.rdata;
                end
            endcase
        end

        // Read data is captured in the setup cycle so it leaves a flop.
        if (apb_setup) begin
            next_state.rdata = '0;
            unique case (paddr_i)
                OFF_CTRL: begin
                    next_state.rdata[CTRL_ENABLE_BIT]     = state.enable;
                    next_state.rdata[CTRL_BEEP_LSB +: 2]  = state.beep_mode;
                    next_state.rdata[CTRL_APPEND_BIT]     = state.append;
                end
                OFF_UPPER_ONE:    next_state.rdata = state.upper_bound_one;
                OFF_LOWER_ONE:    next_state.rdata = state.lower_bound_one;
                OFF_UPPER_TWO:    next_state.rdata = state.upper_bound_two;
                OFF_LOWER_TWO:    next_state.rdata = state.lower_bound_two;
                OFF_LAST_READING: next_state.rdata = state.last_reading;
                OFF_LAST_STATUS: begin
                    // Status rides along with the reading only when asked.
                    if (state.append) begin
                        next_state.rdata[STAT_W-1:0] = state.status;
                    end
                end
                OFF_RECALL_INDEX: next_state.rdata[PTR_W-1:0] = state.recall_index;
                OFF_RECALL_STATUS: begin
                    next_state.rdata[STAT_W-1:0] =
                        state.status_buf[state.recall_index];
                end
                OFF_BUF_COUNT: next_state.rdata[CNT_W-1:0] = state.count;
                default: next_state.rdata = '0;
            endcase
        end
    end

    // State register; reset loads the factory bounds and a quiet beeper.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state                 <= '0;
            state.enable          <= CTRL_ENABLE_RST;
            state.append          <= CTRL_APPEND_RST;
            state.beep_mode       <= DLT_BEEP_NEVER;
            state.upper_bound_one <= UB1_RST;
            state.lower_bound_one <= LB1_RST;
            state.upper_bound_two <= UB2_RST;
            state.lower_bound_two <= LB2_RST;
        end else begin
            state <= next_state;
        end
    end

    // Outputs come from the state flops; pready_o is tied high and pslverr_o is decoded from the bus.
    assign prdata_o                = state.rdata;
    assign pready_o                = 1'b1; // Zero wait states keep the bus simple.
    assign pslverr_o               = apb_access & ~addr_mapped(paddr_i);
    assign status_valid_o          = state.status_valid;
    assign high_o                  = state.status[ST_HIGH];
    assign low_o                   = state.status[ST_LOW];
    assign in_limits_o             = state.status[ST_IN];
    assign inside_short_o          = state.status[ST_INSIDE_S];
    assign fail_set_o              = state.status[ST_SET_LSB +: 2];
    assign range_exceeded_status_o = state.status[ST_RANGE];
    assign beep_normal_o           = state.beep_normal;
    assign beep_lower_o            = state.beep_lower;

endmodule : dlt_tester
`default_nettype wire

// ### dlt_pkg.sv
// Constants, types and register map shared by the dual limit tester.
// Assumes readings arrive as signed micro-units of the active function.
`default_nettype none
package dlt_pkg;
    // Bus and data geometry.
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STAT_W = 8;
    localparam int unsigned BUF_DEPTH = 16;
    localparam int unsigned PTR_W = 4;
    localparam int unsigned CNT_W = 5;

    // One volt, amp or ohm expressed in reading units.
    localparam logic signed [31:0] UNITS_PER_UNIT = 32'sh000f4240;

    // Factory bounds: +1/-1 for set one, +2/-2 for set two.
    localparam logic signed [31:0] UB1_RST = UNITS_PER_UNIT;
    localparam logic signed [31:0] LB1_RST = -UNITS_PER_UNIT;
    localparam logic signed [31:0] UB2_RST = UNITS_PER_UNIT + UNITS_PER_UNIT;
    localparam logic signed [31:0] LB2_RST = -(UNITS_PER_UNIT + UNITS_PER_UNIT);

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_CTRL          = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_UPPER_ONE     = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_LOWER_ONE     = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_UPPER_TWO     = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_LOWER_TWO     = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_LAST_READING  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_LAST_STATUS   = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_RECALL_INDEX  = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_RECALL_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_BUF_COUNT     = 8'h24;

    // Control register fields and reset values.
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_BEEP_LSB   = 1;
    localparam int unsigned CTRL_APPEND_BIT = 3;
    localparam logic CTRL_ENABLE_RST = 1'b1;
    localparam logic CTRL_APPEND_RST = 1'b0;

    // Status word bit positions.
    localparam int unsigned ST_HIGH     = 0;
    localparam int unsigned ST_LOW      = 1;
    localparam int unsigned ST_IN       = 2;
    localparam int unsigned ST_INSIDE_S = 3;
    localparam int unsigned ST_SET_LSB  = 4;
    localparam int unsigned ST_RANGE    = 6;
    localparam int unsigned ST_TESTED   = 7;

    // Failing set numbers.
    localparam logic [1:0] SET_NONE = 2'h0;
    localparam logic [1:0] SET_ONE  = 2'h1;
    localparam logic [1:0] SET_TWO  = 2'h2;

    // Beeper option; code 3 is illegal and acts as never.
    typedef enum logic [1:0] {
        DLT_BEEP_NEVER   = 2'b00,
        DLT_BEEP_OUTSIDE = 2'b01,
        DLT_BEEP_INSIDE  = 2'b10
    } dlt_beep_e;
endpackage : dlt_pkg
`default_nettype wire

// ### dlt_assertions.sv
// Concurrent checks on the ports of the dual limit tester.
// Assumes one clock domain, clk_i, and the asynchronous active-low reset resetn_i.
`default_nettype none
module dlt_assertions
    import dlt_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic       reading_valid_i,
    input wire logic       continuity_function_i,
    input wire logic       channel_closed_i,
    input wire logic       status_valid_o,
    input wire logic       high_o,
    input wire logic       low_o,
    input wire logic       in_limits_o,
    input wire logic       inside_short_o,
    input wire logic [1:0] fail_set_o,
    input wire logic       range_exceeded_status_o,
    input wire logic       beep_normal_o,
    input wire logic       beep_lower_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // A reading that is tested, and the status pulse that shows its verdict.
    sequence s_taken;
        reading_valid_i && !continuity_function_i;
    endsequence
    sequence s_shown;
        status_valid_o;
    endsequence

    // Status levels are only allowed to move together with the status pulse.
    a_status_once: assert property (reading_valid_i |=> s_shown)
        else $error("status pulse missing after a reading");
    a_no_spurious: assert property (!reading_valid_i |=> !status_valid_o)
        else $error("status pulse without a reading");
    a_levels_hold: assert property (!status_valid_o |->
        $stable({high_o, low_o, in_limits_o, inside_short_o, fail_set_o}))
        else $error("status levels moved between readings");
    a_in_clean: assert property (s_shown ##0 (in_limits_o || inside_short_o) |->
        !high_o && !low_o && fail_set_o == SET_NONE)
        else $error("inside status shown with a failure");
    a_fail_numbered: assert property (s_shown ##0 ((high_o || low_o) &&
        !range_exceeded_status_o) |-> fail_set_o != SET_NONE && !(high_o && low_o))
        else $error("failure shown without one set number");
    a_ovf_high: assert property (s_shown ##0 range_exceeded_status_o |->
        high_o && !low_o && !in_limits_o && fail_set_o == SET_NONE)
        else $error("overflow status malformed");
    a_closed_short: assert property (s_taken ##0 channel_closed_i |=> !in_limits_o)
        else $error("closed channel shows normal inside status");
    a_continuity_function_quiet: assert property (reading_valid_i && continuity_function_i |=>
        !(high_o || low_o || in_limits_o || beep_normal_o || beep_lower_o))
        else $error("continuity reading was tested");
    a_beep_align: assert property (beep_normal_o || beep_lower_o |->
        status_valid_o && !(beep_normal_o && beep_lower_o))
        else $error("beep outside a status pulse or both tones");
endmodule // dlt_assertions

bind dlt_tester dlt_assertions i_dlt_assertions (.clk_i(clk_i), .resetn_i(resetn_i),
    .reading_valid_i(reading_valid_i), .continuity_function_i(continuity_function_i),
    .channel_closed_i(channel_closed_i), .status_valid_o(status_valid_o), .high_o(high_o),
    .low_o(low_o), .in_limits_o(in_limits_o), .inside_short_o(inside_short_o),
    .fail_set_o(fail_set_o), .range_exceeded_status_o(range_exceeded_status_o),
    .beep_normal_o(beep_normal_o), .beep_lower_o(beep_lower_o));
`default_nettype wire

// ### dlt_chain_model.sv
// Behavioural model of the processing chain that hands finished readings over.
// Assumes the tester samples every output on the rising edge of clk_i.
`default_nettype none
module dlt_chain_model
    import dlt_pkg::*;
(
    input  wire logic                clk_i,
    output logic                     reading_valid_o,
    output logic signed [DATA_W-1:0] reading_o,
    output logic                     reading_overflow_o,
    output logic                     reading_store_o,
    output logic                     continuity_function_o,
    output logic                     channel_closed_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet chain at time zero.
    initial begin
        {reading_valid_o, reading_o, reading_overflow_o, reading_store_o} = '0;
        {continuity_function_o, channel_closed_o} = 2'b00;
    end

    // One finished reading after gap idle cycles; gap lets the chain be slow.
    task automatic send(input logic signed [DATA_W-1:0] value, input logic ovf, input logic st,
                        input logic continuity_function, input logic closed, input int gap);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        reading_o <= value;
        {reading_valid_o, reading_overflow_o, reading_store_o} <= {1'b1, ovf, st};
        {continuity_function_o, channel_closed_o} <= {continuity_function, closed};
        @(posedge clk_i);
        reading_valid_o <= 1'b0;
        // Released value, overflow and store flip, so nothing may lean on their stale values.
        reading_o <= ~value;
        {reading_overflow_o, reading_store_o} <= ~{ovf, st};
    endtask
endmodule // dlt_chain_model
`default_nettype wire

// ### dlt_tester_tb.sv
// Self-checking bench for the dual limit tester: APB tasks and a reading table.
// Assumes dlt_pkg, the chain model and the checker are compiled before it.
`default_nettype none
module dlt_tester_tb
    import dlt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0]  mode;
        logic [31:0] value;
        logic        ovf;
        logic        closed;
        logic [7:0]  exp_st;
        logic [1:0]  exp_beep;
    } dlt_row_s;
    // Rows: beep mode, reading, overflow, closed, status byte, {lower, normal} beep.
    // Factory set one is tighter than set two, so the inside rows use that option.
    localparam dlt_row_s ROWS [15] = '{
        '{2'h1, 32'h0007a120, 1'b0, 1'b0, 8'h04, 2'h0}, '{2'h1, 32'h0016e360, 1'b0, 1'b0, 8'h11, 2'h1},
        '{2'h1, 32'hffe91ca0, 1'b0, 1'b0, 8'h12, 2'h1}, '{2'h1, 32'h002625a0, 1'b0, 1'b0, 8'h11, 2'h1},
        '{2'h1, 32'h000f4240, 1'b0, 1'b0, 8'h11, 2'h1}, '{2'h1, 32'hffe17b80, 1'b0, 1'b0, 8'h12, 2'h1},
        '{2'h2, 32'h0007a120, 1'b0, 1'b0, 8'h04, 2'h1}, '{2'h2, 32'h0016e360, 1'b0, 1'b0, 8'h11, 2'h2},
        '{2'h2, 32'h002625a0, 1'b0, 1'b0, 8'h11, 2'h0}, '{2'h0, 32'h0016e360, 1'b0, 1'b0, 8'h11, 2'h0},
        '{2'h3, 32'h0016e360, 1'b0, 1'b0, 8'h11, 2'h0}, '{2'h1, 32'hfffffffb, 1'b1, 1'b0, 8'h41, 2'h1},
        '{2'h2, 32'hfffffffb, 1'b1, 1'b0, 8'h41, 2'h0}, '{2'h1, 32'h00000000, 1'b0, 1'b1, 8'h08, 2'h0},
        '{2'h2, 32'hfff0bdc0, 1'b0, 1'b0, 8'h12, 2'h2}};
    logic                     clk, resetn, psel, penable, pwrite, pready, pslverr, e;
    logic [ADDR_W-1:0]        paddr;
    logic [DATA_W-1:0]        pwdata, prdata, q;
    logic                     rv, rovf, rstore, rcont, rclosed, sv, hi, lo, inl, ish, rng, bn, bl;
    logic signed [DATA_W-1:0] rd;
    logic [1:0]               fset;
    int                       n_fail = 0;
    int                       n_checks = 0;

    dlt_tester i_dlt_tester (.clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .reading_valid_i(rv), .reading_i(rd),
        .reading_overflow_i(rovf), .reading_store_i(rstore), .continuity_function_i(rcont),
        .channel_closed_i(rclosed), .status_valid_o(sv), .high_o(hi), .low_o(lo),
        .in_limits_o(inl), .inside_short_o(ish), .fail_set_o(fset),
        .range_exceeded_status_o(rng), .beep_normal_o(bn), .beep_lower_o(bl));
    dlt_chain_model i_dlt_chain_model (.clk_i(clk), .reading_valid_o(rv), .reading_o(rd),
        .reading_overflow_o(rovf), .reading_store_o(rstore), .continuity_function_o(rcont),
        .channel_closed_o(rclosed));

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t register value %h expected %h", $time, got, exp);
        end
    endtask
    // Status is sampled 1 ns after the pulse edge so that its updates have landed.
    task automatic chk_st(input logic [7:0] exp, input logic [1:0] eb);
        logic [9:0] got;
        #1;
        got = {bl, bn, 1'b0, rng, fset, ish, inl, lo, hi};
        n_checks++;
        if (got !== {eb, exp}) begin
            n_fail++;
            $display("BAD %0t status %h expected %h", $time, got, {eb, exp});
        end
    endtask
    // One APB transfer; the request stands until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 64) n_fail++;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic ee);
        apb(1'b0, a, 32'h0);
        chk_reg(q, exp);
        chk_reg({31'h0, e}, {31'h0, ee});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Watchdog, far beyond the some 140 cycles the run needs.
    initial begin
        #(4 * 20000);
        n_fail++;
        test_done();
    end
    // Main sequence: reset values, table, then the awkward cases.
    initial begin
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rdchk(OFF_CTRL, 32'h1, 1'b0);
        rdchk(OFF_UPPER_ONE, UB1_RST, 1'b0);
        rdchk(OFF_LOWER_ONE, LB1_RST, 1'b0);
        rdchk(OFF_UPPER_TWO, UB2_RST, 1'b0);
        rdchk(OFF_LOWER_TWO, LB2_RST, 1'b0);
        rdchk(8'h40, 32'h0, 1'b1);
        foreach (ROWS[i]) begin
            apb(1'b1, OFF_CTRL, {29'h0, ROWS[i].mode, 1'b1});
            i_dlt_chain_model.send(ROWS[i].value, ROWS[i].ovf, 1'b0, 1'b0, ROWS[i].closed, i % 2);
            chk_st(ROWS[i].exp_st, ROWS[i].exp_beep);
            chk_reg({31'h0, sv}, 32'h1);
        end
        i_dlt_chain_model.send(32'h0016e360, 1'b0, 1'b0, 1'b1, 1'b0, 0);
        chk_st(8'h00, 2'h0);
        // Set two narrower than set one, outside beeper, status appended.
        apb(1'b1, OFF_UPPER_TWO, 32'h0007a120);
        apb(1'b1, OFF_LOWER_TWO, 32'hfff85ee0);
        apb(1'b1, OFF_CTRL, 32'h0000000b);
        i_dlt_chain_model.send(32'h000aae60, 1'b0, 1'b0, 1'b0, 1'b0, 0);
        chk_st(8'h21, 2'h1);
        i_dlt_chain_model.send(32'hfff85ee0, 1'b0, 1'b0, 1'b0, 1'b0, 0);
        chk_st(8'h22, 2'h1);
        i_dlt_chain_model.send(32'h0016e360, 1'b0, 1'b1, 1'b0, 1'b0, 0);
        chk_st(8'h11, 2'h1);
        rdchk(OFF_LAST_STATUS, 32'h91, 1'b0);
        rdchk(OFF_BUF_COUNT, 32'h1, 1'b0);
        apb(1'b1, OFF_RECALL_INDEX, 32'h0);
        rdchk(OFF_RECALL_STATUS, 32'h91, 1'b0);
        // A reset in mid-run must bring the factory bounds back.
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rdchk(OFF_UPPER_TWO, UB2_RST, 1'b0);
        chk_reg({31'h0, hi}, 32'h0);
        test_done();
    end
endmodule // dlt_tester_tb
`default_nettype wire
